/* File: design/pms_pkg.sv */
// Purpose : Shared constants and types for the power mode supervisor.
// Assumes : Registers sit on a 32-bit classic Wishbone slave, word aligned.
// Notes   : Offsets are byte addresses.
package pms_pkg;

   // ---------------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------------
   localparam logic [7:0] PMS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] PMS_OFF_STATUS = 8'h04;
   localparam logic [7:0] PMS_OFF_IRQ_ST = 8'h08;
   localparam logic [7:0] PMS_OFF_IRQ_EN = 8'h0C;
   localparam logic [7:0] PMS_OFF_IRQ_CL = 8'h10;

   // ---------------------------------------------------------------------
   // Control, status and interrupt register fields
   // ---------------------------------------------------------------------
   localparam int PMS_CTRL_LEVEL_LSB = 0;
   localparam int PMS_CTRL_DET_EN    = 3;
   localparam int PMS_CTRL_VOLT_SEL  = 4;
   localparam int PMS_CTRL_PD_SEL    = 5;
   localparam int PMS_CTRL_LP_SEL    = 6;
   localparam int PMS_CTRL_WUE_CLR   = 7;

   localparam int PMS_ST_DET_FLAG = 0;
   localparam int PMS_ST_WUE_FLAG = 1;
   localparam int PMS_ST_MODE_LSB = 2;

   localparam int PMS_IRQ_DET  = 0;
   localparam int PMS_IRQ_WAKE = 1;
   localparam int PMS_IRQ_W    = 2;

   localparam logic [7:0] PMS_CTRL_RESET = 8'h00;

   // Cycles of clock restore after a stop exit before the core is released.
   localparam int PMS_RESTORE_NS     = 80;
   localparam int PMS_CLK_PERIOD_NS  = 8;
   localparam int PMS_RESTORE_CYCLES = (PMS_RESTORE_NS + PMS_CLK_PERIOD_NS - 1)
                                       / PMS_CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      PMS_BOR_OFF,
      PMS_BOR_LVL1,
      PMS_BOR_LVL2,
      PMS_BOR_LVL3
   } pms_bor_level_t;

   typedef enum {
      PMS_RUN,
      PMS_SLEEP,
      PMS_STOP,
      PMS_RESTORE,
      PMS_STANDBY
   } pms_mode_t;

   // Core request bundle.
   typedef struct packed {
      logic wait_irq;
      logic wait_evt;
      logic core_deep_sleep_bit;
   } pms_core_req_t;

   // Standby wake sources.
   typedef struct packed {
      logic wakeup_pin;
      logic rtc_alarm;
      logic rtc_wakeup;
      logic rtc_timestamp;
      logic rtc_tamper;
      logic external_reset_pin;
      logic independent_watchdog;
   } pms_wake_src_t;

   // Analog supervisor reports; a 1 means the supply is below the level.
   typedef struct packed {
      logic main_below_por;
      logic analog_below_por;
      logic [3:1] below_bor;
      logic below_detector;
   } pms_supply_t;

endpackage

/* File: design/pms_power_mode_supervisor.sv */
// Purpose : Supply supervision, voltage detector and low-power mode control.
// Assumes : Core wait requests are synchronous one-cycle pulses.
// Notes   : Analog comparators are outside; this block acts on their levels.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps

// Overview of operation
// - Hold chip reset while power-on or power-down supervisor reports low supply.
// - Brown-out level comes from a 2-bit option setting; zero disables it.
// - Hold chip reset while supply is below the chosen brown-out level.
// - Voltage detector flag and interrupt act only while its enable bit is 1.
// - A 3-bit writable level field picks the detector threshold.
// - Read-only status flag follows the detector comparison continuously.
// - Detector crossing in either direction raises an interrupt when enabled.
// - Run mode keeps regulator in normal mode at software-chosen voltage.
// - Stop gates core clocks and peripherals, keeping regulator level.
// - Standby powers down the core domain; wake comes through reset.
// - Three low-power modes exist: sleep, stop and standby.
// - Wait with deep-sleep clear enters sleep; an interrupt wakes a wait for interrupt, an event a wait for event.
// - Wait with deep-sleep set and power-down select 0 enters stop.
// - In stop, regulator low-power select picks normal or low-power mode.
// - Deep-sleep, power-down select 1, wake flag clear: wait enters standby.
module pms_power_mode_supervisor #(
   parameter int RESTORE_CYCLES = pms_pkg::PMS_RESTORE_CYCLES
) (
   input  wire logic                  clk_sys_i,         // System clock, 125 MHz.
   input  wire logic                  rst_n_i,           // Power-on reset, active low.
   input  wire logic [31:0]           wb_adr_i,          // Wishbone address.
   input  wire logic [31:0]           wb_dat_i,          // Wishbone write data.
   input  wire logic [3:0]            wb_sel_i,          // Wishbone byte select.
   input  wire logic                  wb_we_i,           // Wishbone write enable.
   input  wire logic                  wb_cyc_i,          // Wishbone cycle.
   input  wire logic                  wb_stb_i,          // Wishbone strobe.
   output logic [31:0]                wb_dat_o,          // Wishbone read data.
   output logic                       wb_ack_o,          // Wishbone acknowledge.
   input  wire logic [1:0]            bor_option_i,      // Brown-out option level.
   input  wire pms_pkg::pms_supply_t  supply_i,          // Analog supervisor levels.
   input  wire pms_pkg::pms_core_req_t core_req_i,       // Core wait requests.
   input  wire logic                  any_irq_i,         // Any pending interrupt.
   input  wire logic                  event_i,           // Wake-up event to core.
   input  wire logic                  ext_irq_i,         // Any external line event.
   input  wire pms_pkg::pms_wake_src_t wake_src_i,       // Standby wake sources.
   output logic                       chip_reset_n_o,    // Chip reset, active low.
   output logic                       core_clk_en_o,     // Core clock enable.
   output logic                       periph_clk_en_o,   // Core-domain peripheral clocks.
   output logic                       core_power_on_o,   // Core domain power switch.
   output logic                       reg_lowpower_o,    // Regulator low-power mode.
   output logic                       regulator_voltage_select_o, // Regulator level.
   output logic [2:0]                 detector_level_select_o,    // Detector threshold.
   output logic                       irq_o              // Level interrupt.
);

   // ---------------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------------
   localparam int PMS_IRQ_W_L = pms_pkg::PMS_IRQ_W;

   logic [7:0]  ctrl;
   logic [7:0]  next_ctrl;
   logic [PMS_IRQ_W_L-1:0] irq_en;
   logic [PMS_IRQ_W_L-1:0] next_irq_en;
   logic        ack;
   logic        next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic        wr_stb;
   logic [7:0]  adr;
   logic [PMS_IRQ_W_L-1:0] irq_clr;
   logic [PMS_IRQ_W_L-1:0] irq_st;
   logic [PMS_IRQ_W_L-1:0] next_irq_st;
   logic [PMS_IRQ_W_L-1:0] irq_set;
   logic        det_flag;
   logic        det_flag_d;
   logic        wue_flag;
   logic        next_wue_flag;
   logic        wue_clr;
   pms_pkg::pms_mode_t mode;
   pms_pkg::pms_mode_t next_mode;

   assign adr    = wb_adr_i[7:0];
   // A write lands on the edge at which the master sees ack high.
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0];
   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;

   always_comb begin
      next_ctrl   = ctrl;
      next_irq_en = irq_en;
      irq_clr     = '0;
      wue_clr     = 1'b0;
      next_ack    = wb_cyc_i && wb_stb_i && !ack;
      next_rdata  = rdata;
      if (wr_stb) begin
         case (adr)
            pms_pkg::PMS_OFF_CTRL: begin
               next_ctrl = wb_dat_i[7:0];
               wue_clr   = wb_dat_i[pms_pkg::PMS_CTRL_WUE_CLR];
               next_ctrl[pms_pkg::PMS_CTRL_WUE_CLR] = 1'b0;
            end
            pms_pkg::PMS_OFF_IRQ_EN: next_irq_en = wb_dat_i[PMS_IRQ_W_L-1:0];
            pms_pkg::PMS_OFF_IRQ_CL: irq_clr = wb_dat_i[PMS_IRQ_W_L-1:0];
            default: ;
         endcase
      end
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack) begin
         case (adr)
            pms_pkg::PMS_OFF_CTRL:   next_rdata = {24'h000000, ctrl};
            pms_pkg::PMS_OFF_STATUS: next_rdata = {27'h0000000, 3'(mode),
                                                   wue_flag, det_flag};
            pms_pkg::PMS_OFF_IRQ_ST: next_rdata = {30'h00000000, irq_st};
            pms_pkg::PMS_OFF_IRQ_EN: next_rdata = {30'h00000000, irq_en};
            default:                 next_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ctrl   <= pms_pkg::PMS_CTRL_RESET;
         irq_en <= '0;
         ack    <= 1'b0;
         rdata  <= 32'h00000000;
      end else begin
         ctrl   <= next_ctrl;
         irq_en <= next_irq_en;
         ack    <= next_ack;
         rdata  <= next_rdata;
      end
   end

   // ---------------------------------------------------------------------
   // Supply supervision and voltage detector
   // ---------------------------------------------------------------------
   logic bor_trip;

   always_comb begin
      case (pms_pkg::pms_bor_level_t'(bor_option_i))
         pms_pkg::PMS_BOR_LVL1: bor_trip = supply_i.below_bor[1];
         pms_pkg::PMS_BOR_LVL2: bor_trip = supply_i.below_bor[2];
         pms_pkg::PMS_BOR_LVL3: bor_trip = supply_i.below_bor[3];
         default:               bor_trip = 1'b0;
      endcase
   end

   // Supervisor resets are level driven and need no software action.
   assign chip_reset_n_o = rst_n_i && !supply_i.main_below_por
                           && !supply_i.analog_below_por && !bor_trip;

   assign detector_level_select_o = ctrl[pms_pkg::PMS_CTRL_LEVEL_LSB +: 3];
   assign det_flag = ctrl[pms_pkg::PMS_CTRL_DET_EN] && supply_i.below_detector;

   always_comb begin
      irq_set = '0;
      irq_set[pms_pkg::PMS_IRQ_DET]  = ctrl[pms_pkg::PMS_CTRL_DET_EN]
                                       && (det_flag != det_flag_d);
      irq_set[pms_pkg::PMS_IRQ_WAKE] = (mode == pms_pkg::PMS_RESTORE)
                                       && (next_mode == pms_pkg::PMS_RUN);
      // A set in the same cycle as a clear wins.
      next_irq_st = (irq_st & ~irq_clr) | irq_set;
      next_wue_flag = (wue_flag && !wue_clr) || event_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         det_flag_d <= 1'b0;
         irq_st     <= '0;
         wue_flag   <= 1'b0;
      end else begin
         det_flag_d <= det_flag;
         irq_st     <= next_irq_st;
         wue_flag   <= next_wue_flag;
      end
   end

   assign irq_o = |(irq_st & irq_en);

   // ---------------------------------------------------------------------
   // Low-power mode control
   // ---------------------------------------------------------------------
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic       wait_req;
   logic       wfe_mode;
   logic       next_wfe_mode;

   assign wait_req = core_req_i.wait_irq || core_req_i.wait_evt;

   always_comb begin
      next_mode     = mode;
      next_cnt      = cnt;
      next_wfe_mode = wfe_mode;
      case (mode)
         pms_pkg::PMS_RUN: begin
            if (wait_req) begin
               next_wfe_mode = core_req_i.wait_evt;
               if (!core_req_i.core_deep_sleep_bit) begin
                  next_mode = pms_pkg::PMS_SLEEP;
               end else if (!ctrl[pms_pkg::PMS_CTRL_PD_SEL]) begin
                  next_mode = pms_pkg::PMS_STOP;
               end else if (!wue_flag) begin
                  next_mode = pms_pkg::PMS_STANDBY;
               end
            end
         end
         pms_pkg::PMS_SLEEP: begin
            if (wfe_mode ? event_i : any_irq_i) begin
               next_mode = pms_pkg::PMS_RUN;
            end
         end
         pms_pkg::PMS_STOP: begin
            if (ext_irq_i) begin
               next_mode = pms_pkg::PMS_RESTORE;
               next_cnt  = 8'(RESTORE_CYCLES);
            end
         end
         pms_pkg::PMS_RESTORE: begin
            // The core stays halted until the clock restore time has run out.
            if (cnt <= 8'h01) begin
               next_mode = pms_pkg::PMS_RUN;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         pms_pkg::PMS_STANDBY: begin
            // Wake from standby is a full reset of the core domain.
            if (|wake_src_i) begin
               next_mode = pms_pkg::PMS_RUN;
            end
         end
         default: next_mode = pms_pkg::PMS_RUN;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mode     <= pms_pkg::PMS_RUN;
         cnt      <= 8'h00;
         wfe_mode <= 1'b0;
      end else begin
         mode     <= next_mode;
         cnt      <= next_cnt;
         wfe_mode <= next_wfe_mode;
      end
   end

   // Clocks and power follow the mode register, one cycle after a wait request.
   assign core_clk_en_o   = (mode == pms_pkg::PMS_RUN);
   assign periph_clk_en_o = (mode == pms_pkg::PMS_RUN) || (mode == pms_pkg::PMS_SLEEP);
   assign core_power_on_o = (mode != pms_pkg::PMS_STANDBY);
   assign reg_lowpower_o  = (mode == pms_pkg::PMS_STOP)
                            && ctrl[pms_pkg::PMS_CTRL_LP_SEL];
   assign regulator_voltage_select_o = ctrl[pms_pkg::PMS_CTRL_VOLT_SEL];

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   a_sleep_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_RUN && wait_req && !core_req_i.core_deep_sleep_bit
      |=> mode == pms_pkg::PMS_SLEEP) else $error("sleep not entered");
   a_stop_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_RUN && wait_req && core_req_i.core_deep_sleep_bit
      && !ctrl[pms_pkg::PMS_CTRL_PD_SEL] |=> mode == pms_pkg::PMS_STOP)
      else $error("stop not entered");
   a_standby_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_RUN && wait_req && core_req_i.core_deep_sleep_bit
      && ctrl[pms_pkg::PMS_CTRL_PD_SEL] && !wue_flag
      |=> mode == pms_pkg::PMS_STANDBY) else $error("standby not entered");
   a_standby_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_STANDBY && |wake_src_i |=> core_power_on_o)
      else $error("standby wake missed");
   a_stop_restore: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_STOP && ext_irq_i |=> !core_clk_en_o ##[1:300] core_clk_en_o)
      else $error("stop exit not restored");
   a_det_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !ctrl[pms_pkg::PMS_CTRL_DET_EN] |-> !det_flag) else $error("detector active off");
   a_det_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $changed(det_flag) && ctrl[pms_pkg::PMS_CTRL_DET_EN] && $past(ctrl[pms_pkg::PMS_CTRL_DET_EN])
      |=> irq_st[pms_pkg::PMS_IRQ_DET]) else $error("detector irq missed");
   a_bor_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      bor_option_i == 2'h3 && supply_i.below_bor[3] |-> !chip_reset_n_o)
      else $error("brown-out not holding reset");
   a_stop_reg: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_STOP |-> reg_lowpower_o == ctrl[pms_pkg::PMS_CTRL_LP_SEL])
      else $error("stop regulator mode wrong");
   // These check mode exits, the wake flag block, the supervisor reset levels and the stop clock gating.
   a_sleep_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_SLEEP && (wfe_mode ? event_i : any_irq_i)
      |=> mode == pms_pkg::PMS_RUN) else $error("sleep wake missed");
   a_reset_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      supply_i.main_below_por || supply_i.analog_below_por |-> !chip_reset_n_o)
      else $error("supply reset not holding");
   a_bor_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      bor_option_i == 2'h0 && !supply_i.main_below_por && !supply_i.analog_below_por
      |-> chip_reset_n_o) else $error("brown-out active while off");
   a_wue_block: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_RUN && wait_req && core_req_i.core_deep_sleep_bit
      && ctrl[pms_pkg::PMS_CTRL_PD_SEL] && wue_flag |=> mode == pms_pkg::PMS_RUN)
      else $error("standby entered with wake flag");
   a_wake_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_RESTORE && cnt <= 8'h01
      |=> core_clk_en_o && irq_st[pms_pkg::PMS_IRQ_WAKE]) else $error("restore end wrong");
   a_stop_clocks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      mode == pms_pkg::PMS_STOP |-> !core_clk_en_o && !periph_clk_en_o && core_power_on_o)
      else $error("stop clocks running");

endmodule // pms_power_mode_supervisor

/* File: tb/pms_core_model.sv */
// Purpose : Behavioural processor core that issues wait requests.
// Assumes : The bench commands one wait instruction at a time.
// Notes   : A halted core cannot execute a wait instruction.
`timescale 1ns/10ps
module pms_core_model (
   input  wire logic              clk_sys_i,     // System clock.
   input  wire logic              rst_n_i,       // Reset, active low.
   input  wire logic              run_wait_i,    // Execute one wait instruction.
   input  wire logic              use_evt_i,     // Wait for event, not interrupt.
   input  wire logic              deep_i,        // Deep-sleep bit to present.
   input  wire logic              core_clk_en_i, // Core clock running.
   output pms_pkg::pms_core_req_t core_req_o     // Requests to the supervisor.
);
   pms_pkg::pms_core_req_t next_req;
   always_comb begin
      next_req.core_deep_sleep_bit = deep_i;
      next_req.wait_irq = run_wait_i && !use_evt_i && core_clk_en_i;
      next_req.wait_evt = run_wait_i && use_evt_i && core_clk_en_i;
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         core_req_o <= '0;
      end else begin
         core_req_o <= next_req;
      end
   end
endmodule // pms_core_model

/* File: tb/test_power_mode_supervisor.sv */
// Purpose : Self-checking bench for the power mode supervisor.
// Assumes : One 125 MHz clock; the core model sits on the far side.
// Notes   : Random stimulus from a fixed seed, with corner cases.
`timescale 1ns/10ps
module test_power_mode_supervisor;
   localparam int RC    = 4;
   localparam int LIMIT = 20000;
   logic                   clk_sys_i = 1'b0;
   logic                   rst_n_i = 1'b0;
   logic [31:0]            adr = '0, wdat = '0, rd, dat_o;
   logic                   we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
   logic [1:0]             bor_opt = '0;
   pms_pkg::pms_supply_t   sup = '0;
   pms_pkg::pms_core_req_t req;
   pms_pkg::pms_wake_src_t wake = '0;
   logic                   any_irq = 1'b0, evt = 1'b0, ext_irq = 1'b0;
   logic                   run_wait = 1'b0, use_evt = 1'b0, deep = 1'b0;
   logic                   chip_rst_n, core_clk, periph_clk, core_pwr, reg_lp, volt, irq;
   logic [2:0]             det_lvl;
   int                     failures = 0, n_tests = 0, cycles = 0, i, n;
   logic [7:0]             v;

   pms_power_mode_supervisor #(.RESTORE_CYCLES(RC)) pms_power_mode_supervisor_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .bor_option_i(bor_opt), .supply_i(sup), .core_req_i(req),
      .any_irq_i(any_irq), .event_i(evt), .ext_irq_i(ext_irq), .wake_src_i(wake),
      .chip_reset_n_o(chip_rst_n), .core_clk_en_o(core_clk), .periph_clk_en_o(periph_clk),
      .core_power_on_o(core_pwr), .reg_lowpower_o(reg_lp),
      .regulator_voltage_select_o(volt), .detector_level_select_o(det_lvl), .irq_o(irq));
   pms_core_model pms_core_model_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .run_wait_i(run_wait), .use_evt_i(use_evt),
      .deep_i(deep), .core_clk_en_i(core_clk), .core_req_o(req));

   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask
   // Classic single cycle: hold everything until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {cyc, stb, we} <= {2'b11, w};
      adr <= {24'h0, a};
      wdat <= d;
      do begin
         tick(1);
      end while (ack !== 1'b1);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
      tick(1);
   endtask
   task automatic core_wait(input logic e, input logic d);
      {deep, use_evt} <= {d, e};
      tick(1);
      run_wait <= 1'b1;
      tick(1);
      run_wait <= 1'b0;
      tick(3);
   endtask
   function automatic logic exp_rst_n(input logic [1:0] o, input pms_pkg::pms_supply_t s);
      return !(s.main_below_por || s.analog_below_por || (o != 2'h0 && s.below_bor[o]));
   endfunction

   initial begin
      void'($urandom(32'hEF0E13AF));
      tick(12);
      rst_n_i <= 1'b1;
      tick(1);
      wb(0, pms_pkg::PMS_OFF_CTRL, '0);
      check(rd, 32'h0);
      wb(1, 8'h20, 32'hFF);
      wb(0, 8'h20, '0);
      check(rd, 32'h0);
      $display("test reset and map done");
      for (i = 0; i < 24; i++) begin
         bor_opt <= (i < 4) ? 2'(i) : 2'($urandom);
         sup <= (i < 4) ? 6'h0E : 6'($urandom) & 6'h3E;
         tick(2);
         check(chip_rst_n, exp_rst_n(bor_opt, sup));
      end
      sup <= '0;
      $display("test supervisors done");
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom);
         wb(1, pms_pkg::PMS_OFF_CTRL, {24'h0, v});
         wb(0, pms_pkg::PMS_OFF_CTRL, '0);
         check(rd, {24'h0, v & 8'h7F});
         check({volt, det_lvl, core_clk, reg_lp}, {v[4], v[2:0], 2'b10});
      end
      $display("test control done");
      wb(1, pms_pkg::PMS_OFF_CTRL, 32'h08);
      wb(1, pms_pkg::PMS_OFF_IRQ_EN, 32'h1);
      wb(1, pms_pkg::PMS_OFF_IRQ_CL, 32'h3);
      check(irq, 1'b0);
      for (i = 0; i < 2; i++) begin
         sup.below_detector <= !i[0];
         tick(3);
         wb(0, pms_pkg::PMS_OFF_STATUS, '0);
         check(rd[0], !i[0]);
         check(irq, 1'b1);
         wb(1, pms_pkg::PMS_OFF_IRQ_CL, 32'h1);
         check(irq, 1'b0);
      end
      sup.below_detector <= 1'b1;
      tick(3);
      wb(1, pms_pkg::PMS_OFF_IRQ_EN, 32'h0);
      check(irq, 1'b0);
      wb(0, pms_pkg::PMS_OFF_IRQ_ST, '0);
      check(rd[0], 1'b1);
      wb(1, pms_pkg::PMS_OFF_CTRL, 32'h0);
      wb(1, pms_pkg::PMS_OFF_IRQ_CL, 32'h3);
      sup.below_detector <= 1'b0;
      tick(3);
      sup.below_detector <= 1'b1;
      tick(3);
      wb(0, pms_pkg::PMS_OFF_STATUS, '0);
      check(rd[0], 1'b0);
      wb(0, pms_pkg::PMS_OFF_IRQ_ST, '0);
      check(rd[0], 1'b0);
      sup.below_detector <= 1'b0;
      $display("test detector done");
      wb(1, pms_pkg::PMS_OFF_CTRL, 32'hA0);
      for (i = 0; i < 7; i++) begin
         core_wait(1'($urandom), 1'b1);
         check({core_clk, periph_clk, core_pwr}, 3'b000);
         wake <= 7'h1 << i;
         tick(1);
         wake <= '0;
         tick(3);
         check(core_pwr, 1'b1);
      end
      $display("test standby done");
      for (i = 0; i < 2; i++) begin
         wb(1, pms_pkg::PMS_OFF_CTRL, {24'h0, 1'b0, i[0], 6'h10});
         core_wait(i[0], 1'b1);
         check({core_clk, periph_clk, core_pwr, reg_lp, volt}, {3'b001, i[0], 1'b1});
         ext_irq <= 1'b1;
         tick(1);
         ext_irq <= 1'b0;
         n = 0;
         while (core_clk !== 1'b1 && n < 40) begin
            tick(1);
            n++;
         end
         check(n >= RC && n <= RC + 3, 1'b1);
         wb(0, pms_pkg::PMS_OFF_IRQ_ST, '0);
         check(rd[1], 1'b1);
         wb(1, pms_pkg::PMS_OFF_IRQ_CL, 32'h3);
      end
      $display("test stop done");
      wb(1, pms_pkg::PMS_OFF_CTRL, 32'h0);
      core_wait(1'b0, 1'b0);
      wb(0, pms_pkg::PMS_OFF_STATUS, '0);
      check({rd[4:2], core_clk, periph_clk, core_pwr}, {3'h1, 3'b011});
      any_irq <= 1'b1;
      tick(1);
      any_irq <= 1'b0;
      tick(3);
      check(core_clk, 1'b1);
      core_wait(1'b1, 1'b0);
      check(core_clk, 1'b0);
      evt <= 1'b1;
      tick(1);
      evt <= 1'b0;
      tick(3);
      check(core_clk, 1'b1);
      $display("test sleep done");
      wb(0, pms_pkg::PMS_OFF_STATUS, '0);
      check(rd[1], 1'b1);
      wb(1, pms_pkg::PMS_OFF_CTRL, 32'h20);
      core_wait(1'b0, 1'b1);
      check({core_clk, core_pwr}, 2'b11);
      wb(1, pms_pkg::PMS_OFF_CTRL, 32'h80);
      wb(0, pms_pkg::PMS_OFF_STATUS, '0);
      check(rd[1], 1'b0);
      $display("test wake flag done");
      final_report();
   end
endmodule // test_power_mode_supervisor
